// file: tws_consts.svh
// register offsets, field positions, status codes and timing counts of the two-wire slave
`ifndef TWS_CONSTS_SVH
`define TWS_CONSTS_SVH
`define TWS_OFF_CTRL   8'h00
`define TWS_OFF_STAT   8'h04
`define TWS_OFF_DATA   8'h08
`define TWS_OFF_OWN    8'h0C
`define TWS_B_EN       6
`define TWS_B_STA      5
`define TWS_B_STO      4
`define TWS_B_SI       3
`define TWS_B_AA       2
`define TWS_RST_BYTE   8'h00
`define TWS_ST_START   8'h08
`define TWS_ST_SW_AK   8'h60
`define TWS_ST_LSW_AK  8'h68
`define TWS_ST_GC_AK   8'h70
`define TWS_ST_LGC_AK  8'h78
`define TWS_ST_DW_AK   8'h80
`define TWS_ST_DW_NK   8'h88
`define TWS_ST_DG_AK   8'h90
`define TWS_ST_DG_NK   8'h98
`define TWS_ST_STOP    8'hA0
`define TWS_ST_SR_AK   8'hA8
`define TWS_ST_LSR_AK  8'hB0
`define TWS_ST_DT_AK   8'hB8
`define TWS_ST_DT_NK   8'hC0
`define TWS_ST_LAST_AK 8'hC8
`define TWS_ST_NONE    8'hF8
`define TWS_CLK_NS     4
`define TWS_T_HDSTA_NS 4000
`define TWS_HDSTA_CYC  ((`TWS_T_HDSTA_NS + `TWS_CLK_NS - 1) / `TWS_CLK_NS)
`define TWS_RESP_OK    2'b00
`define TWS_RESP_ERR   2'b10
`endif

// file: tws_pkg.sv
// types shared by the two-wire slave
package tws_pkg;
  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_RX, S_ACKOUT, S_TX, S_ACKIN, S_HOLD, S_START
  } tws_state_t;
  // what the slave currently is, for bench visibility through mode_o (no register shows it)
  typedef struct packed {
    logic addressed;  // addressed as slave
    logic transmit;   // slave transmit when set, receive otherwise
    logic general;    // addressed by general call
  } tws_mode_t;
endpackage

// file: tws_slave.sv
// two-wire slave receiver/transmitter with AXI4-Lite registers
// How it works
// RULE1 - 88h with ack clear: ignore own and general call
// RULE2 - ack set: own address, general call if enabled
// RULE3 - start request set: START once bus free
// RULE4 - after 90h receive next byte, ack per bit
// RULE5 - general call byte nacked reports 98h
// RULE6 - stop or restart while addressed reports A0h; here only while addressed in receive mode
// RULE7 - software loads own address upper seven bits
// RULE8 - address bit zero enables general call response
// RULE9 - software sets enable and acknowledge bits
// RULE10 - software clears start and stop requests; here hardware clears the stop request when the flag is serviced
// RULE11 - read bit selects transmit, else receive
// RULE12 - after address flag set with valid status
// RULE13 - lost arbitration then read reports B0h
// RULE14 - ack bit cleared marks last sent byte
// RULE15 - after last byte C0h on nack, C8h on ack
// RULE16 - after last byte ignore master, release data
// RULE17 - ack bit zero: no own address response
// RULE18 - setting ack bit resumes address recognition
// RULE19 - ack bit cleared: nack next received byte
// RULE20 - status reads F8h while flag clear
//
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "tws_consts.svh"
module tws_slave (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // axi4-lite write
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  // two-wire pins, enables low while pulling the line low
  input  wire logic             scl_i,
  output logic                  scl_o,
  output logic                  scl_oe_n,
  input  wire logic             sda_i,
  output logic                  sda_o,
  output logic                  sda_oe_n,
  // slave mode, for observation
  output tws_pkg::tws_mode_t    mode_o
);
  import tws_pkg::*;

  // cycles that the generated start holds data low before the flag is set; the clock is never pulled
  localparam int unsigned HDSTA = `TWS_HDSTA_CYC;

  // pin synchronisers; scl_s[0] and sda_s[0] are read only by the next stage
  logic [2:0] scl_s, sda_s;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
    end else begin
      scl_s <= {scl_s[1:0], scl_i};
      sda_s <= {sda_s[1:0], sda_i};
    end
  end
  wire scl_rise  = scl_s[1] & ~scl_s[2];
  wire scl_fall  = ~scl_s[1] & scl_s[2];
  wire start_ev  = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
  wire stop_ev   = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];

  // axi state
  logic        aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
  logic [7:0]  awa_q, awa_d;
  logic [7:0]  wd_q, wd_d;
  logic        ws_q, ws_d;
  logic [1:0]  br_q, br_d, rr_q, rr_d;
  logic [31:0] rd_q, rd_d;
  logic        wr_go;                    // both write channels taken

  // protocol state
  tws_state_t  st_q, st_d;
  logic [3:0]  cnt_q, cnt_d;             // bit counter
  logic [7:0]  sh_q, sh_d;               // shift register
  logic [11:0] tmr_q, tmr_d;             // start hold timer
  logic        ack_q, ack_d;             // ack to send or ack seen
  logic        gc_q, gc_d, rw_q, rw_d, adr_q, adr_d;
  logic        last_q, last_d, cont_q, cont_d, lost_q, lost_d;
  logic        pend_q, pend_d, free_q, free_d;
  // software-visible fields
  logic        en_q, en_d, sta_q, sta_d, sto_q, sto_d, si_q, si_d, aa_q, aa_d;
  logic [7:0]  stat_q, stat_d, dat_q, dat_d, own_q, own_d;
  logic        own_hit, gc_hit;

  // status shown to software
  function automatic logic [7:0] stat_view(input logic si, input logic [7:0] st);
    stat_view = si ? st : `TWS_ST_NONE;  // see RULE20
  endfunction

  // register read mux, shared by the read path
  function automatic logic [31:0] reg_rd(input logic [7:0] a);
    case (a)
      `TWS_OFF_CTRL: reg_rd = {24'h0, 1'b0, en_q, sta_q, sto_q, si_q, aa_q, 2'b00};
      `TWS_OFF_STAT: reg_rd = {24'h0, stat_view(si_q, stat_q)};
      `TWS_OFF_DATA: reg_rd = {24'h0, dat_q};
      `TWS_OFF_OWN:  reg_rd = {24'h0, own_q};
      default:       reg_rd = 32'h0;
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `TWS_OFF_CTRL) || (a == `TWS_OFF_STAT) || (a == `TWS_OFF_DATA) || (a == `TWS_OFF_OWN);
  endfunction

  // axi handshakes: each channel taken once, answer after both
  assign s_axi_awready = !aw_q && !bv_q;
  assign s_axi_wready  = !w_q && !bv_q;
  assign s_axi_arready = !rv_q;
  assign s_axi_bvalid  = bv_q;
  assign s_axi_bresp   = br_q;
  assign s_axi_rvalid  = rv_q;
  assign s_axi_rresp   = rr_q;
  assign s_axi_rdata   = rd_q;
  assign wr_go = aw_q && w_q;

  // axi next state
  always_comb begin
    aw_d = aw_q; awa_d = awa_q; w_d = w_q; wd_d = wd_q; ws_d = ws_q;
    bv_d = bv_q; br_d = br_q; rv_d = rv_q; rr_d = rr_q; rd_d = rd_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_d  = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_d  = 1'b1;
      wd_d = s_axi_wdata[7:0];
      ws_d = s_axi_wstrb[0];             // all registers sit in byte lane 0
    end
    if (wr_go) begin
      aw_d = 1'b0;
      w_d  = 1'b0;
      bv_d = 1'b1;
      br_d = mapped(awa_q) ? `TWS_RESP_OK : `TWS_RESP_ERR;
    end else if (bv_q && s_axi_bready) begin
      bv_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rv_d = 1'b1;
      rd_d = reg_rd(s_axi_araddr);
      rr_d = mapped(s_axi_araddr) ? `TWS_RESP_OK : `TWS_RESP_ERR;
    end else if (rv_q && s_axi_rready) begin
      rv_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0; awa_q <= 8'h00; w_q <= 1'b0; wd_q <= 8'h00; ws_q <= 1'b0;
      bv_q <= 1'b0; br_q <= 2'b00; rv_q <= 1'b0; rr_q <= 2'b00; rd_q <= 32'h0;
    end else begin
      aw_q <= aw_d; awa_q <= awa_d; w_q <= w_d; wd_q <= wd_d; ws_q <= ws_d;
      bv_q <= bv_d; br_q <= br_d; rv_q <= rv_d; rr_q <= rr_d; rd_q <= rd_d;
    end
  end

  // address match, gated by enable and the acknowledge bit
  assign own_hit = en_q && aa_q && (sh_q[7:1] == own_q[7:1]);                 // see RULE17 RULE18
  assign gc_hit  = en_q && aa_q && own_q[0] && (sh_q == 8'h00);               // see RULE8 RULE2

  // protocol next state; hardware events are applied after software writes so a set wins
  always_comb begin
    st_d = st_q; cnt_d = cnt_q; sh_d = sh_q; tmr_d = tmr_q; ack_d = ack_q;
    gc_d = gc_q; rw_d = rw_q; adr_d = adr_q; last_d = last_q; cont_d = cont_q;
    lost_d = lost_q; pend_d = pend_q; free_d = free_q;
    en_d = en_q; sta_d = sta_q; sto_d = sto_q; si_d = si_q; aa_d = aa_q;
    stat_d = stat_q; dat_d = dat_q; own_d = own_q;
    // software writes
    if (wr_go && ws_q) begin
      case (awa_q)
        `TWS_OFF_CTRL: begin
          en_d  = wd_q[`TWS_B_EN];
          sta_d = wd_q[`TWS_B_STA];
          sto_d = wd_q[`TWS_B_STO];
          aa_d  = wd_q[`TWS_B_AA];
          if (!wd_q[`TWS_B_SI]) begin
            si_d = 1'b0;                 // writing zero services the flag
          end
        end
        `TWS_OFF_DATA: dat_d = wd_q;
        `TWS_OFF_OWN:  own_d = wd_q;
        default: ;
      endcase
    end
    if (stop_ev) begin
      free_d = 1'b1;
    end else if (start_ev) begin
      free_d = 1'b0;
    end
    case (st_q)
      S_IDLE: begin
        // not addressed: only a start or our own pending start request wakes us, extra clocks are ignored
        if (start_ev) begin
          st_d  = S_ADDR;
          cnt_d = 4'h0;
          if (pend_q) begin
            lost_d = 1'b1;               // another master took the bus first
          end
        end else if (pend_q && free_q && !si_q && en_q) begin
          st_d  = S_START;               // see RULE3
          tmr_d = 12'h000;
        end
      end
      S_ADDR, S_RX: begin
        if (scl_rise) begin
          sh_d  = {sh_q[6:0], sda_s[1]};
          cnt_d = cnt_q + 4'h1;
        end else if (scl_fall && cnt_q == 4'h8) begin
          st_d = S_ACKOUT;
          if (st_q == S_ADDR) begin
            ack_d = own_hit || (gc_hit && !sh_q[0]);
            gc_d  = !own_hit;
            rw_d  = own_hit && sh_q[0];  // see RULE11
          end else begin
            ack_d = aa_q;                // see RULE19 RULE4
            dat_d = sh_q;
          end
        end
      end
      S_ACKOUT: begin
        if (scl_fall) begin
          if (!adr_q && !ack_q) begin
            st_d = S_IDLE;               // not for us
          end else begin
            st_d = S_HOLD;
            si_d = 1'b1;                 // see RULE12
            if (!adr_q) begin
              adr_d  = 1'b1;
              cont_d = 1'b1;
              if (rw_q) begin
                stat_d = lost_q ? `TWS_ST_LSR_AK : `TWS_ST_SR_AK;   // see RULE13
              end else if (gc_q) begin
                stat_d = lost_q ? `TWS_ST_LGC_AK : `TWS_ST_GC_AK;
              end else begin
                stat_d = lost_q ? `TWS_ST_LSW_AK : `TWS_ST_SW_AK;
              end
            end else begin
              cont_d = ack_q;
              if (gc_q) begin
                stat_d = ack_q ? `TWS_ST_DG_AK : `TWS_ST_DG_NK;     // see RULE5
              end else begin
                stat_d = ack_q ? `TWS_ST_DW_AK : `TWS_ST_DW_NK;
              end
            end
          end
        end
      end
      S_TX: begin
        if (scl_fall) begin
          sh_d  = {sh_q[6:0], 1'b1};
          cnt_d = cnt_q + 4'h1;
          if (cnt_q == 4'h7) begin
            st_d = S_ACKIN;
          end
        end
      end
      S_ACKIN: begin
        if (scl_rise) begin
          ack_d = ~sda_s[1];
        end else if (scl_fall) begin
          st_d   = S_HOLD;
          si_d   = 1'b1;
          cont_d = ack_q && !last_q;
          if (ack_q) begin
            stat_d = last_q ? `TWS_ST_LAST_AK : `TWS_ST_DT_AK;      // see RULE15
          end else begin
            stat_d = `TWS_ST_DT_NK;
          end
        end
      end
      S_HOLD: begin
        // clock is stretched while the flag waits, but only when the transfer goes on
        if (!si_q) begin
          sto_d = 1'b0;
          cnt_d = 4'h0;
          if (cont_q && rw_q) begin
            st_d   = S_TX;
            sh_d   = dat_q;
            last_d = !aa_q;              // see RULE14
          end else if (cont_q) begin
            st_d = S_RX;
          end else begin
            st_d   = S_IDLE;             // see RULE1 RULE2 RULE6 RULE16
            adr_d  = 1'b0;
            lost_d = 1'b0;
            pend_d = sta_q;              // see RULE3
          end
        end
      end
      S_START: begin
        tmr_d = tmr_q + 12'h001;
        if (tmr_q == 12'(HDSTA - 1)) begin
          st_d   = S_HOLD;
          si_d   = 1'b1;
          cont_d = 1'b0;
          pend_d = 1'b0;
          stat_d = `TWS_ST_START;
        end
      end
      default: st_d = S_IDLE;
    endcase
    // bus conditions inside a transfer
    if ((start_ev || stop_ev) && st_q != S_IDLE && st_q != S_START && st_q != S_HOLD) begin
      if (adr_q && !rw_q) begin
        st_d   = S_HOLD;                 // see RULE6
        si_d   = 1'b1;
        cont_d = 1'b0;
        stat_d = `TWS_ST_STOP;
      end else begin
        st_d  = start_ev ? S_ADDR : S_IDLE;
        cnt_d = 4'h0;
        adr_d = 1'b0;
      end
    end
    if (!en_q) begin
      st_d  = S_IDLE;                    // disabled interface leaves the bus alone
      adr_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= S_IDLE; cnt_q <= 4'h0; sh_q <= `TWS_RST_BYTE; tmr_q <= 12'h000;
      ack_q <= 1'b0; gc_q <= 1'b0; rw_q <= 1'b0; adr_q <= 1'b0; last_q <= 1'b0;
      cont_q <= 1'b0; lost_q <= 1'b0; pend_q <= 1'b0; free_q <= 1'b1;
      en_q <= 1'b0; sta_q <= 1'b0; sto_q <= 1'b0; si_q <= 1'b0; aa_q <= 1'b0;
      stat_q <= `TWS_ST_NONE; dat_q <= `TWS_RST_BYTE; own_q <= `TWS_RST_BYTE;
    end else begin
      st_q <= st_d; cnt_q <= cnt_d; sh_q <= sh_d; tmr_q <= tmr_d;
      ack_q <= ack_d; gc_q <= gc_d; rw_q <= rw_d; adr_q <= adr_d; last_q <= last_d;
      cont_q <= cont_d; lost_q <= lost_d; pend_q <= pend_d; free_q <= free_d;
      en_q <= en_d; sta_q <= sta_d; sto_q <= sto_d; si_q <= si_d; aa_q <= aa_d;
      stat_q <= stat_d; dat_q <= dat_d; own_q <= own_d;
    end
  end

  // pins: data pulled low for ack, zero bits and start; released otherwise (ones)
  assign sda_o    = 1'b0;
  assign scl_o    = 1'b0;
  // a generated start keeps data low until serviced: letting go while the clock is high would be a stop
  assign sda_oe_n = !((st_q == S_ACKOUT && ack_q) || (st_q == S_TX && !sh_q[7]) || st_q == S_START ||
                      (st_q == S_HOLD && stat_q == `TWS_ST_START));    // see RULE3
  assign scl_oe_n = !(st_q == S_HOLD && cont_q);
  assign mode_o   = '{addressed: adr_q, transmit: rw_q, general: gc_q};

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_status_none: assert property (rv_q && !$past(si_q) && $past(s_axi_arvalid && s_axi_arready && s_axi_araddr == `TWS_OFF_STAT) |-> rd_q[7:0] == 8'hF8) else $error("status not F8 with flag clear"); // see RULE20
  chk_gc_enable: assert property (st_q == S_ADDR && scl_fall && cnt_q == 4'h8 && !own_q[0] && sh_q == 8'h00 |=> !ack_q) else $error("general call acked while disabled"); // see RULE8
  chk_aa_isolate: assert property ($rose(adr_q) |-> $past(aa_q, 2)) else $error("addressed with ack bit clear"); // see RULE17
  chk_nack_release: assert property (st_q == S_ACKOUT && !ack_q |-> sda_oe_n) else $error("data driven during nack"); // see RULE19
  chk_rx_nack: assert property (st_q == S_RX && scl_fall && cnt_q == 4'h8 && !aa_q |=> st_q == S_ACKOUT && !ack_q) else $error("nack not chosen"); // see RULE19
  chk_idle_release: assert property (st_q == S_IDLE |-> sda_oe_n && scl_oe_n) else $error("bus driven when not addressed"); // see RULE16
  chk_addr_flag: assert property (st_q == S_ACKOUT && ack_q && !adr_q && scl_fall |=> si_q && adr_q && st_q == S_HOLD) else $error("flag not set after address"); // see RULE12
  chk_tx_mode: assert property (st_q == S_HOLD && !si_q && cont_q && rw_q |=> st_q == S_TX ##0 last_q == !$past(aa_q)) else $error("transmit not entered"); // see RULE11 RULE14
  chk_last_code: assert property (st_q == S_ACKIN && scl_fall && last_q && ack_q |=> stat_q == 8'hC8 && !cont_q) else $error("last byte ack code wrong"); // see RULE15
  chk_nk_leave: assert property (st_q == S_HOLD && !si_q && !cont_q |=> st_q == S_IDLE && !adr_q) else $error("not left to unaddressed"); // see RULE1
endmodule // tws_slave

// file: tws_bus_master.sv
// behavioural two-wire bus master that faces the slave across the link
`timescale 1ns/10ps
module tws_bus_master #(
  parameter int HALF_NS = 32  // half of the 64 ns link period
) (
  // resolved line levels, pulled up when nobody pulls
  input  wire logic scl_line,
  input  wire logic sda_line,
  // high while this master pulls a line low
  output logic      scl_pull,
  output logic      sda_pull
);
  localparam int Q = HALF_NS / 2;  // data changes a quarter period before clock rises

  // lines released until the bench asks for traffic
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end

  // start or repeated start from either bus state
  task automatic start_c;
    sda_pull = 1'b0;
    #Q;
    scl_pull = 1'b0;
    wait (scl_line);
    #Q;
    sda_pull = 1'b1;
    #HALF_NS;
    scl_pull = 1'b1;
    #Q;
  endtask

  // one clock pulse; waits out a slave that stretches the low phase
  task automatic bit_x(input logic b, output logic r);
    sda_pull = !b;
    #Q;
    scl_pull = 1'b0;
    wait (scl_line);
    #Q;
    r = sda_line;
    #Q;
    scl_pull = 1'b1;
    #Q;
  endtask

  // byte to the slave, nk is the level seen in the ack slot
  task automatic byte_w(input logic [7:0] d, output logic nk);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
    end
    bit_x(1'b1, nk);
  endtask

  // byte from the slave, nak decides our answer
  task automatic byte_r(input logic nak, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, d[i]);
    end
    bit_x(nak, r);
  endtask

  // stop: data rises while clock is high
  task automatic stop_c;
    sda_pull = 1'b1;
    #Q;
    scl_pull = 1'b0;
    wait (scl_line);
    #Q;
    sda_pull = 1'b0;
    #HALF_NS;
  endtask
endmodule // tws_bus_master

// file: tws_slave_tb.sv
// self-checking bench of the two-wire slave with a bus master model
`timescale 1ns/10ps
`include "tws_consts.svh"
module tws_slave_tb;
  import tws_pkg::*;
  logic aclk = 1'b0;
  logic aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, scl_oe_n, sda_oe_n, scl_pull, sda_pull;
  logic [7:0] awaddr, araddr, v, d, t;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [6:0] own;
  logic nk;
  tws_mode_t mode_o;
  int num_errors = 0;
  int samples_checked = 0;
  // wired-and lines with pull-ups
  wire logic scl = scl_oe_n & !scl_pull;
  wire logic sda = sda_oe_n & !sda_pull;

  always #2 aclk = ~aclk;

  tws_slave uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .scl_i(scl), .scl_o(),
    .scl_oe_n(scl_oe_n), .sda_i(sda), .sda_o(), .sda_oe_n(sda_oe_n), .mode_o(mode_o));

  tws_bus_master m (.scl_line(scl), .sda_line(sda), .scl_pull(scl_pull), .sda_pull(sda_pull));

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  // readys are looked at mid-cycle, so the edge that takes a channel is known
  task automatic axw(input logic [7:0] a, input logic [7:0] dd);
    logic ta, tw, tb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, dd};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    for (int n = 0; n < 100 && !tb; n++) begin
      @(negedge aclk);
      ta = awready;
      tw = wready;
      tb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (!tb) num_errors++;
  endtask

  task automatic axr(input logic [7:0] a, output logic [7:0] dd, output logic [1:0] rr);
    logic ta, tr;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    tr = 1'b0;
    for (int n = 0; n < 100 && !tr; n++) begin
      @(negedge aclk);
      ta = arready;
      tr = rvalid;
      dd = rdata[7:0];
      rr = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    if (!tr) num_errors++;
  endtask

  // control byte: enable always on, start request and acknowledge as asked, flag cleared
  function automatic logic [7:0] cv(input logic begin_condition_request, input logic aa);
    cv = 8'h00;
    cv[`TWS_B_EN] = 1'b1;
    cv[`TWS_B_STA] = begin_condition_request;
    cv[`TWS_B_AA] = aa;
  endfunction

  // the state moves on at the edge that ends the write, so outputs are looked at a half cycle later
  task automatic svc(input logic begin_condition_request, input logic aa);
    axw(`TWS_OFF_CTRL, cv(begin_condition_request, aa));
    @(negedge aclk);
  endtask

  task automatic st(input logic [7:0] e);
    axr(`TWS_OFF_STAT, v, r);
    chk(v, e);
    chk({6'h0, r}, {6'h0, `TWS_RESP_OK});
  endtask

  task automatic adr(input logic [7:0] b, input logic enk);
    m.start_c();
    m.byte_w(b, nk);
    chk({7'h0, nk}, {7'h0, enk});
  endtask

  task automatic rxb(input logic [7:0] b, input logic enk);
    m.byte_w(b, nk);
    chk({7'h0, nk}, {7'h0, enk});
  endtask

  task automatic txb(input logic nak, input logic [7:0] e);
    m.byte_r(nak, v);
    chk(v, e);
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // cuts a hung handshake or stretched clock short
  initial begin
    #200000;
    num_errors++;
    results();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    void'($urandom(49192));
    own = 7'($urandom_range(1, 127));
    d = 8'($urandom);
    t = 8'($urandom);
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    st(`TWS_ST_NONE);
    axr(8'h10, v, r);
    chk({6'h0, r}, {6'h0, `TWS_RESP_ERR});
    axw(8'h10, 8'h00);
    chk({6'h0, r}, {6'h0, `TWS_RESP_ERR});
    axw(`TWS_OFF_OWN, {own, 1'b1});
    chk({6'h0, r}, {6'h0, `TWS_RESP_OK});
    svc(1'b0, 1'b1);
    // own write: one byte acked, then acknowledge cleared
    adr({own, 1'b0}, 1'b0);
    st(`TWS_ST_SW_AK);
    chk({5'h0, mode_o}, 8'h04);
    svc(1'b0, 1'b1);
    rxb(d, 1'b0);
    st(`TWS_ST_DW_AK);
    axr(`TWS_OFF_DATA, v, r);
    chk(v, d);
    svc(1'b0, 1'b0);
    rxb(d, 1'b1);
    st(`TWS_ST_DW_NK);
    svc(1'b0, 1'b0);
    chk({5'h0, mode_o}, 8'h00);
    adr({own, 1'b0}, 1'b1);
    adr(8'h00, 1'b1);
    m.stop_c();
    svc(1'b0, 1'b1);
    // read with the last byte flagged by a cleared acknowledge bit
    adr({own, 1'b1}, 1'b0);
    st(`TWS_ST_SR_AK);
    chk({5'h0, mode_o}, 8'h06);
    axw(`TWS_OFF_DATA, t);
    svc(1'b0, 1'b0);
    txb(1'b0, t);
    st(`TWS_ST_LAST_AK);
    svc(1'b0, 1'b1);
    txb(1'b1, 8'hFF);
    st(`TWS_ST_NONE);
    m.stop_c();
    // general call, then its nacked byte serviced with a start request
    adr(8'h00, 1'b0);
    st(`TWS_ST_GC_AK);
    chk({5'h0, mode_o}, 8'h05);
    svc(1'b0, 1'b1);
    rxb(d, 1'b0);
    st(`TWS_ST_DG_AK);
    svc(1'b0, 1'b0);
    rxb(t, 1'b1);
    st(`TWS_ST_DG_NK);
    svc(1'b1, 1'b1);
    m.stop_c();
    v = 8'h00;
    for (int n = 0; n < 600 && v !== `TWS_ST_START; n++) begin
      axr(`TWS_OFF_STAT, v, r);
    end
    chk(v, `TWS_ST_START);
    chk({7'h0, sda}, 8'h00);
    svc(1'b0, 1'b1);
    // stop while addressed, then own address still recognised
    adr({own, 1'b0}, 1'b0);
    svc(1'b0, 1'b1);
    m.stop_c();
    st(`TWS_ST_STOP);
    svc(1'b0, 1'b1);
    chk({5'h0, mode_o}, 8'h00);
    adr({own, 1'b1}, 1'b0);
    axw(`TWS_OFF_DATA, d);
    svc(1'b0, 1'b1);
    txb(1'b1, d);
    st(`TWS_ST_DT_NK);
    svc(1'b1, 1'b1);
    // a foreign start while ours waits for a free bus: lost arbitration, then read
    adr({own, 1'b1}, 1'b0);
    st(`TWS_ST_LSR_AK);
    svc(1'b0, 1'b0);
    txb(1'b1, d);
    st(`TWS_ST_DT_NK);
    svc(1'b0, 1'b1);
    m.stop_c();
    // general call ignored once its enable is off
    axw(`TWS_OFF_OWN, {own, 1'b0});
    adr(8'h00, 1'b1);
    m.stop_c();
    results();
  end
endmodule // tws_slave_tb
